// file: servo_monitor_defs.svh
`ifndef SERVO_MONITOR_DEFS_SVH
`define SERVO_MONITOR_DEFS_SVH

// Clock rate and activity hold time for the command pulse flags
`define CLK_FREQ_MHZ      40
`define PULSE_HOLD_US     1000

// Monitor item numbers
`define ITEM_SPEED_FB     4'h0
`define ITEM_SPEED_CMD    4'h1
`define ITEM_TORQUE       4'h2
`define ITEM_U_PULSES     4'h3
`define ITEM_ELEC_ANGLE   4'h4
`define ITEM_STATUS_ONE   4'h5
`define ITEM_STATUS_TWO   4'h6
`define ITEM_PULSE_SPEED  4'h7
`define ITEM_DEVIATION    4'h8
`define ITEM_PULSE_COUNT  4'h9
`define ITEM_FIRST        4'h0
`define ITEM_LAST         4'h9
`define ITEM_COUNT        10
`define STEP_UNITS        5'h01
`define STEP_TENS         5'h0A

// Encoder counts in a quarter turn, four quarters a turn
`define QTR_TURN_COUNTS   32'h0000_0800
`define QTRS_PER_TURN     32'h0000_0004

// Register byte offsets
`define OFS_CTRL          12'h000
`define OFS_THRESH        12'h004
`define OFS_STATUS        12'h008
`define OFS_VALUE         12'h00C
`define OFS_WORD_ONE      12'h010
`define OFS_WORD_TWO      12'h014
`define OFS_PULSE_COUNT   12'h018

// Control register fields and reset value
`define CTRL_DIR_BIT      0
`define CTRL_SEL_BIT      1
`define CTRL_RST          32'h0000_0000
`define COUNT_RST         32'h0000_0000

// Display status register fields
`define STAT_ITEM_LSB     0
`define STAT_ITEM_MSB     3
`define STAT_SHOW_BIT     8
`define STAT_DIGIT_BIT    9
`define STAT_MODE_LSB     12
`define STAT_MODE_MSB     13

// Status word one segment positions (bit n sits at n-1)
`define W1_ALARM          0
`define W1_BRAKE          1
`define W1_REVERSE        2
`define W1_ROT_LIMIT      3
`define W1_SPEED_REACHED  4
`define W1_PROP_ONLY      5
`define W1_FWD_LIMIT      6
`define W1_REV_LIMIT      7
`define W1_ENERGIZED      8
`define W1_ENC_A          9
`define W1_ENC_B          10
`define W1_ENC_Z          11
`define W1_POLE_U         12
`define W1_POLE_V         13
`define W1_POLE_W         14
`define W1_RUN            15
`define W1_MULTI          16
`define W1_FWD_INHIBIT    17
`define W1_REV_INHIBIT    18
`define W1_SPARE          19

// Status word two segment positions
`define W2_CLOCKWISE      0
`define W2_COUNTER_CW     1
`define W2_DEV_CLEAR      2
`define W2_SPARE_LSB      3
`define W2_SPARE_MSB      19

`endif

// file: servo_monitor_pkg.sv
package servo_monitor_pkg;

	// Display modes, Gray coded along the mode-key cycle
	typedef enum logic [1:0] {
		MODE_STATUS     = 2'h0,
		MODE_SETTINGS   = 2'h1,
		MODE_MONITOR    = 2'h3,
		MODE_ALARM_HIST = 2'h2
	} disp_mode_t;

	// Pins from outside the clock domain
	typedef struct packed {
		logic key_mode;
		logic key_data;
		logic key_up;
		logic key_down;
		logic key_left;
		logic key_right;
		logic enc_a;
		logic enc_b;
		logic enc_z;
		logic pole_sense_u;
		logic pole_sense_v;
		logic pole_sense_w;
		logic fwd_limit_speed_sel_a;
		logic rev_limit_speed_sel_b;
		logic run_cmd;
		logic multifunction_input;
		logic fwd_drive_inhibit;
		logic rev_drive_inhibit;
		logic clockwise_pulse_in;
		logic counterclockwise_pulse_in;
		logic deviation_clear_in;
	} pin_in_t;

	// Flags from the drive's own logic, same clock
	typedef struct packed {
		logic alarm_active_flag;
		logic dyn_brake_active;
		logic torque_limited;
		logic speed_reached_flag;
		logic prop_only_control;
		logic motor_energized;
		logic pulse_train_ctrl;
	} drive_flags_t;

	// Monitored quantities from the control loops, same clock
	typedef struct packed {
		logic signed [31:0] speed_fb;
		logic signed [31:0] speed_cmd;
		logic signed [31:0] torque_pct;
		logic signed [31:0] u_phase_pulses;
		logic signed [31:0] elec_angle_deg;
		logic signed [31:0] cmd_pulse_rpm;
		logic signed [31:0] position_deviation;
	} quantities_t;

	// Display drive toward the parameter unit
	typedef struct packed {
		disp_mode_t  mode;
		logic [3:0]  item;
		logic        digit_tens;
		logic        show_value;
		logic        show_bits;
		logic [31:0] value;
		logic [19:0] segments;
	} display_t;

endpackage

// file: servo_monitor_display_select.sv
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "servo_monitor_defs.svh"
// Summary of operation
// R1: Ten monitor items, numbered 00 to 09
// R2: Item 00 shows motor speed
// R3: Item 01 speed command, zero under pulses
// R4: Item 02 torque command in percent
// R5: Item 03 encoder counts from U edge
// R6: Item 04 electrical angle in degrees
// R7: Item 07 command pulse rate as speed
// R8: Item 08 remaining position deviation
// R9: Item 09 accumulates input pulses, one model
// R10: Mode, up/down/shift, data toggles value
// R11: Items 05, 06 show 20 segment bits
// R12: Word one: alarm, braking, reverse mode
// R13: Bit 4 rotation or torque limit, selectable
// R14: Bit 5 speed reached, bit 6 P-control
// R15: Bits 7, 8 limit/speed select inputs
// R16: Bit 9 lit while motor energized
// R17: Bits 10-12 encoder, polarity per model
// R18: Bits 13-15 pole sensor U, V, W
// R19: Bits 16-19 run, multi, inhibits; 20 unused
// R20: Word two: pulses, deviation clear, rest unused
// R21: Status mode at reset, mode key cycles
// R22: Item number clamped to defined items
module servo_monitor_display_select #(
	parameter int          ADDR_W         = 12,
	parameter logic        HAS_PULSE_CNT  = 1'b1,
	parameter logic        ENC_LIT_ON_SIG = 1'b1,
	parameter logic [31:0] THRESH_RESET   = 32'h0000_0014,
	parameter int          PULSE_HOLD_CYC =
		`PULSE_HOLD_US * `CLK_FREQ_MHZ
) (
	input  wire logic                         CLK_I,
	input  wire logic                         RESET_N_I,
	input  wire logic                         PSEL_I,
	input  wire logic                         PENABLE_I,
	input  wire logic                         PWRITE_I,
	input  wire logic [ADDR_W-1:0]            PADDR_I,
	input  wire logic [31:0]                  PWDATA_I,
	output logic      [31:0]                  PRDATA_O,
	output logic                              PREADY_O,
	output logic                              PSLVERR_O,
	input  wire servo_monitor_pkg::pin_in_t   PIN_I,
	input  wire servo_monitor_pkg::drive_flags_t FLAGS_I,
	input  wire servo_monitor_pkg::quantities_t  QUANT_I,
	output servo_monitor_pkg::display_t       DISPLAY_O
);

	localparam int PIN_W = $bits(servo_monitor_pkg::pin_in_t);
	localparam int HOLD_W = $clog2(PULSE_HOLD_CYC + 1);
	localparam logic [31:0] TURN_MASK =
		(`QTR_TURN_COUNTS * `QTRS_PER_TURN) - 32'h0000_0001;

	// Byte address match on all ADDR_W address bits
	function automatic logic addr_is(input logic [ADDR_W-1:0] a,
		input logic [11:0] ofs);
		addr_is = (a == ADDR_W'(ofs));
	endfunction

	// ---------------- Pin synchronisers ----------------
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] s1_q;
	logic [PIN_W-1:0] s2_q;
	logic [PIN_W-1:0] s3_q;
	logic [PIN_W-1:0] flt_q;
	logic [PIN_W-1:0] prev_q;
	logic [PIN_W-1:0] rise;
	servo_monitor_pkg::pin_in_t pin;
	servo_monitor_pkg::pin_in_t press;

	assign pin_raw = PIN_I;

	// Three stages; a level counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < PIN_W; gi++) begin : g_sync
			always_ff @(posedge CLK_I) begin
				if (!RESET_N_I) begin
					s1_q[gi]   <= 1'b0;
					s2_q[gi]   <= 1'b0;
					s3_q[gi]   <= 1'b0;
					flt_q[gi]  <= 1'b0;
					prev_q[gi] <= 1'b0;
				end else begin
					s1_q[gi]   <= pin_raw[gi];
					s2_q[gi]   <= s1_q[gi];
					s3_q[gi]   <= s2_q[gi];
					flt_q[gi]  <= (s2_q[gi] == s3_q[gi]) ?
						s3_q[gi] : flt_q[gi];
					prev_q[gi] <= flt_q[gi];
				end
			end
		end
	endgenerate

	// One-cycle pulse on each accepted rising level
	assign rise  = flt_q & ~prev_q;
	assign pin   = flt_q;
	assign press = rise;

	// ---------------- Register file ----------------
	logic [31:0] ctrl_q;
	logic [31:0] thresh_q;
	logic [31:0] prdata_q;
	logic        setup;
	logic        access;
	logic        hit;
	logic        wr_ctrl;
	logic        wr_thresh;
	logic        wr_count;
	logic [31:0] rd_mux;

	assign setup  = PSEL_I & ~PENABLE_I;
	assign access = PSEL_I & PENABLE_I;
	assign hit = addr_is(PADDR_I, `OFS_CTRL) |
		addr_is(PADDR_I, `OFS_THRESH) |
		addr_is(PADDR_I, `OFS_STATUS) |
		addr_is(PADDR_I, `OFS_VALUE) |
		addr_is(PADDR_I, `OFS_WORD_ONE) |
		addr_is(PADDR_I, `OFS_WORD_TWO) |
		addr_is(PADDR_I, `OFS_PULSE_COUNT);

	// Zero wait states; unmapped addresses answer with an error
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = access & ~hit;
	assign PRDATA_O  = prdata_q;

	assign wr_ctrl   = access & PWRITE_I & addr_is(PADDR_I, `OFS_CTRL);
	assign wr_thresh = access & PWRITE_I &
		addr_is(PADDR_I, `OFS_THRESH);
	assign wr_count  = access & PWRITE_I &
		addr_is(PADDR_I, `OFS_PULSE_COUNT);

	// Writable registers
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			ctrl_q   <= `CTRL_RST;
			thresh_q <= THRESH_RESET;
		end else begin
			if (wr_ctrl)
				ctrl_q <= PWDATA_I;
			if (wr_thresh)
				thresh_q <= PWDATA_I;
		end
	end

	// Read data captured in the setup cycle, so it stands from a flop
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I)
			prdata_q <= 32'h0000_0000;
		else if (setup)
			prdata_q <= rd_mux;
	end

	// ---------------- Display mode and item selection ----------------
	servo_monitor_pkg::disp_mode_t mode_q;
	servo_monitor_pkg::disp_mode_t mode_d;
	logic [3:0] item_q;
	logic [3:0] item_d;
	logic       show_q;
	logic       show_d;
	logic       tens_q;
	logic       tens_d;
	logic       in_monitor;
	logic [4:0] step;
	logic [4:0] item_wide;
	logic [4:0] item_sum;
	logic [3:0] item_up;
	logic [3:0] item_dn;

	assign in_monitor = (mode_q == servo_monitor_pkg::MODE_MONITOR);
	assign step       = tens_q ? `STEP_TENS : `STEP_UNITS;
	assign item_wide  = {1'b0, item_q};
	assign item_sum   = item_wide + step;

	// Saturate rather than wrap: an overshoot lands on the end item
	assign item_up = (item_sum > {1'b0, `ITEM_LAST}) ?
		`ITEM_LAST : item_sum[3:0]; // R22
	assign item_dn = (item_wide < step + {1'b0, `ITEM_FIRST}) ?
		`ITEM_FIRST : 4'(item_wide - step); // R22

	// Mode key cycles the four display modes
	always_comb begin
		mode_d = mode_q;
		if (press.key_mode) begin
			unique case (mode_q)
				servo_monitor_pkg::MODE_STATUS:
					mode_d = servo_monitor_pkg::MODE_SETTINGS; // R21
				servo_monitor_pkg::MODE_SETTINGS:
					mode_d = servo_monitor_pkg::MODE_MONITOR; // R10
				servo_monitor_pkg::MODE_MONITOR:
					mode_d = servo_monitor_pkg::MODE_ALARM_HIST; // R10
				servo_monitor_pkg::MODE_ALARM_HIST:
					mode_d = servo_monitor_pkg::MODE_STATUS; // R21
			endcase
		end
	end

	// Keys only edit the item while in monitor mode; up beats down
	always_comb begin
		item_d = item_q;
		show_d = show_q;
		tens_d = tens_q;
		if (press.key_mode) begin
			show_d = 1'b0;
			tens_d = 1'b0;
		end else if (in_monitor) begin
			if (press.key_data)
				show_d = ~show_q; // R10
			else if (!show_q && press.key_up)
				item_d = item_up; // R10
			else if (!show_q && press.key_down)
				item_d = item_dn; // R10
			else if (!show_q && press.key_left)
				tens_d = 1'b1; // R10
			else if (!show_q && press.key_right)
				tens_d = 1'b0; // R10
		end
	end

	// Power-up lands in the status display
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			mode_q <= servo_monitor_pkg::MODE_STATUS; // R21
			item_q <= `ITEM_FIRST;
			show_q <= 1'b0;
			tens_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			item_q <= item_d;
			show_q <= show_d;
			tens_q <= tens_d;
		end
	end

	// ---------------- Command pulse activity and counter ----------------
	logic [1:0]        pulse_edge;
	logic [1:0]        pulse_busy;
	logic [HOLD_W-1:0] hold_q [2];

	assign pulse_edge = {press.counterclockwise_pulse_in,
		press.clockwise_pulse_in};

	// Retriggered hold makes a pulse train read as a steady level
	generate
		for (gi = 0; gi < 2; gi++) begin : g_hold
			always_ff @(posedge CLK_I) begin
				if (!RESET_N_I)
					hold_q[gi] <= '0;
				else if (pulse_edge[gi])
					hold_q[gi] <= HOLD_W'(PULSE_HOLD_CYC);
				else if (hold_q[gi] != '0)
					hold_q[gi] <= hold_q[gi] - HOLD_W'(1);
			end
			assign pulse_busy[gi] = (hold_q[gi] != '0);
		end
	endgenerate

	logic [31:0] count_q;
	logic [31:0] count_base;
	logic [31:0] count_step;

	// A clear never swallows a pulse arriving in the same cycle
	assign count_base = wr_count ? `COUNT_RST : count_q;
	assign count_step = (pulse_edge == 2'h1) ? 32'h0000_0001 :
		(pulse_edge == 2'h2) ? 32'hFFFF_FFFF : 32'h0000_0000;

	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I)
			count_q <= `COUNT_RST;
		else if (HAS_PULSE_CNT)
			count_q <= count_base + count_step; // R9
	end

	// ---------------- Status words ----------------
	logic [31:0] speed_abs;
	logic        rot_detected;
	logic        rot_or_limit;
	logic [2:0]  enc_view;
	logic [19:0] word_one;
	logic [19:0] word_two;

	assign speed_abs = QUANT_I.speed_fb[31] ?
		32'(-QUANT_I.speed_fb) : QUANT_I.speed_fb;
	assign rot_detected = (speed_abs >= thresh_q); // R13
	assign rot_or_limit = ctrl_q[`CTRL_SEL_BIT] ?
		FLAGS_I.torque_limited : rot_detected; // R13
	// One model lights on signal, the other dims on signal
	assign enc_view = {pin.enc_z, pin.enc_b, pin.enc_a} ^
		{3{~ENC_LIT_ON_SIG}}; // R17

	assign word_one[`W1_ALARM]   = FLAGS_I.alarm_active_flag; // R12
	assign word_one[`W1_BRAKE]   = FLAGS_I.dyn_brake_active; // R12
	assign word_one[`W1_REVERSE] = ctrl_q[`CTRL_DIR_BIT]; // R12
	assign word_one[`W1_ROT_LIMIT]     = rot_or_limit; // R13
	assign word_one[`W1_SPEED_REACHED] = FLAGS_I.speed_reached_flag; // R14
	assign word_one[`W1_PROP_ONLY]     = FLAGS_I.prop_only_control; // R14
	assign word_one[`W1_FWD_LIMIT] = pin.fwd_limit_speed_sel_a; // R15
	assign word_one[`W1_REV_LIMIT] = pin.rev_limit_speed_sel_b; // R15
	assign word_one[`W1_ENERGIZED] = FLAGS_I.motor_energized; // R16
	assign word_one[`W1_ENC_A] = enc_view[0]; // R17
	assign word_one[`W1_ENC_B] = enc_view[1]; // R17
	assign word_one[`W1_ENC_Z] = enc_view[2]; // R17
	assign word_one[`W1_POLE_U] = pin.pole_sense_u; // R18
	assign word_one[`W1_POLE_V] = pin.pole_sense_v; // R18
	assign word_one[`W1_POLE_W] = pin.pole_sense_w; // R18
	assign word_one[`W1_RUN]         = pin.run_cmd; // R19
	assign word_one[`W1_MULTI]       = pin.multifunction_input; // R19
	assign word_one[`W1_FWD_INHIBIT] = pin.fwd_drive_inhibit; // R19
	assign word_one[`W1_REV_INHIBIT] = pin.rev_drive_inhibit; // R19
	assign word_one[`W1_SPARE]       = 1'b0; // R19

	assign word_two[`W2_CLOCKWISE]  = pulse_busy[0]; // R20
	assign word_two[`W2_COUNTER_CW] = pulse_busy[1]; // R20
	assign word_two[`W2_DEV_CLEAR]  = pin.deviation_clear_in; // R20
	assign word_two[`W2_SPARE_MSB:`W2_SPARE_LSB] = '0; // R20

	// ---------------- Item value selection ----------------
	logic [31:0] item_val [`ITEM_COUNT];
	logic [31:0] sel_val;
	logic        sel_bits;

	assign item_val[`ITEM_SPEED_FB] = QUANT_I.speed_fb; // R2
	// Under pulse-train control there is no speed-loop command
	assign item_val[`ITEM_SPEED_CMD] = FLAGS_I.pulse_train_ctrl ?
		32'h0000_0000 : QUANT_I.speed_cmd; // R3
	assign item_val[`ITEM_TORQUE] = QUANT_I.torque_pct; // R4
	// Position within one turn from the U-phase edge
	assign item_val[`ITEM_U_PULSES] =
		QUANT_I.u_phase_pulses & TURN_MASK; // R5
	assign item_val[`ITEM_ELEC_ANGLE] = QUANT_I.elec_angle_deg; // R6
	assign item_val[`ITEM_STATUS_ONE] = {12'h000, word_one}; // R11
	assign item_val[`ITEM_STATUS_TWO] = {12'h000, word_two}; // R11
	assign item_val[`ITEM_PULSE_SPEED] = QUANT_I.cmd_pulse_rpm; // R7
	assign item_val[`ITEM_DEVIATION] = QUANT_I.position_deviation; // R8
	assign item_val[`ITEM_PULSE_COUNT] = count_q; // R9

	assign sel_val  = item_val[item_q]; // R1
	assign sel_bits = (item_q == `ITEM_STATUS_ONE) |
		(item_q == `ITEM_STATUS_TWO); // R11

	// ---------------- Read multiplexer ----------------
	logic [31:0] stat_word;

	assign stat_word[`STAT_ITEM_MSB:`STAT_ITEM_LSB] = item_q;
	assign stat_word[`STAT_SHOW_BIT-1:`STAT_ITEM_MSB+1] = '0;
	assign stat_word[`STAT_SHOW_BIT]  = show_q;
	assign stat_word[`STAT_DIGIT_BIT] = tens_q;
	assign stat_word[`STAT_MODE_LSB-1:`STAT_DIGIT_BIT+1] = '0;
	assign stat_word[`STAT_MODE_MSB:`STAT_MODE_LSB] = mode_q;
	assign stat_word[31:`STAT_MODE_MSB+1] = '0;

	assign rd_mux =
		addr_is(PADDR_I, `OFS_CTRL)        ? ctrl_q :
		addr_is(PADDR_I, `OFS_THRESH)      ? thresh_q :
		addr_is(PADDR_I, `OFS_STATUS)      ? stat_word :
		addr_is(PADDR_I, `OFS_VALUE)       ? sel_val :
		addr_is(PADDR_I, `OFS_WORD_ONE)    ? {12'h000, word_one} :
		addr_is(PADDR_I, `OFS_WORD_TWO)    ? {12'h000, word_two} :
		addr_is(PADDR_I, `OFS_PULSE_COUNT) ? count_q :
		32'h0000_0000;

	// ---------------- Display drive ----------------
	servo_monitor_pkg::display_t disp_q;

	// Registered so the unit sees one coherent snapshot per cycle
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			disp_q <= '0;
		end else begin
			disp_q.mode       <= mode_q;
			disp_q.item       <= item_q;
			disp_q.digit_tens <= tens_q;
			disp_q.show_value <= show_q & in_monitor;
			disp_q.show_bits  <= show_q & in_monitor & sel_bits;
			disp_q.value      <= sel_val;
			disp_q.segments   <= sel_bits ? sel_val[19:0] : 20'h00000;
		end
	end

	assign DISPLAY_O = disp_q;

endmodule

// file: servo_monitor_display_select_properties.sv
`timescale 1ns/1ps
module servo_monitor_checker (
	input wire logic                            CLK_I,
	input wire logic                            RESET_N_I,
	input wire servo_monitor_pkg::drive_flags_t FLAGS_I,
	input wire servo_monitor_pkg::display_t     DISPLAY_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESET_N_I);

	// Successor of each display mode along the key cycle
	function automatic servo_monitor_pkg::disp_mode_t nxt(
		servo_monitor_pkg::disp_mode_t m);
		case (m)
			servo_monitor_pkg::MODE_STATUS:
				return servo_monitor_pkg::MODE_SETTINGS;
			servo_monitor_pkg::MODE_SETTINGS:
				return servo_monitor_pkg::MODE_MONITOR;
			servo_monitor_pkg::MODE_MONITOR:
				return servo_monitor_pkg::MODE_ALARM_HIST;
			default:
				return servo_monitor_pkg::MODE_STATUS;
		endcase
	endfunction

	// Status mode holds for a few edges after release
	property p_reset_mode;
		$rose(RESET_N_I) |->
			(DISPLAY_O.mode == servo_monitor_pkg::MODE_STATUS)[*3];
	endproperty
	a_reset_mode: assert property (p_reset_mode) else
		$error("mode not status after reset");
	// Mode only steps to its successor
	property p_mode_cycle;
		$changed(DISPLAY_O.mode) |->
			DISPLAY_O.mode == nxt($past(DISPLAY_O.mode));
	endproperty
	a_mode_cycle: assert property (p_mode_cycle) else
		$error("mode out of order");
	property p_item_range;
		DISPLAY_O.item <= 4'h9;
	endproperty
	a_item_range: assert property (p_item_range) else
		$error("item beyond nine");
	// Item number frozen while a value is shown
	property p_item_frozen;
		DISPLAY_O.show_value && $past(DISPLAY_O.show_value) |->
			$stable(DISPLAY_O.item);
	endproperty
	a_item_frozen: assert property (p_item_frozen) else
		$error("item moved in value view");
	property p_bits_items;
		DISPLAY_O.show_bits |->
			DISPLAY_O.item == 4'h5 || DISPLAY_O.item == 4'h6;
	endproperty
	a_bits_items: assert property (p_bits_items) else
		$error("bit view on wrong item");
	// Steady alarm and energized flags must show on their segments; spares stay dark
	property p_alarm_seg;
		$stable(FLAGS_I.alarm_active_flag)[*3] ##0
			(DISPLAY_O.show_bits && DISPLAY_O.item == 4'h5) |->
			DISPLAY_O.segments[0] == FLAGS_I.alarm_active_flag;
	endproperty
	a_alarm_seg: assert property (p_alarm_seg) else
		$error("alarm segment wrong");
	property p_energized_seg;
		$stable(FLAGS_I.motor_energized)[*3] ##0
			(DISPLAY_O.show_bits && DISPLAY_O.item == 4'h5) |->
			DISPLAY_O.segments[8] == FLAGS_I.motor_energized;
	endproperty
	a_energized_seg: assert property (p_energized_seg) else
		$error("energized segment wrong");
	property p_spare_one;
		DISPLAY_O.show_bits && DISPLAY_O.item == 4'h5 |->
			!DISPLAY_O.segments[19];
	endproperty
	a_spare_one: assert property (p_spare_one) else
		$error("word one spare lit");
	property p_spare_two;
		DISPLAY_O.show_bits && DISPLAY_O.item == 4'h6 |->
			DISPLAY_O.segments[19:3] == 17'h00000;
	endproperty
	a_spare_two: assert property (p_spare_two) else
		$error("word two spares lit");
	// Pulse-train control forces the speed command to zero
	property p_cmd_zero;
		FLAGS_I.pulse_train_ctrl[*4] ##0
			(DISPLAY_O.show_value && DISPLAY_O.item == 4'h1) |->
			DISPLAY_O.value == 32'h0000_0000;
	endproperty
	a_cmd_zero: assert property (p_cmd_zero) else
		$error("speed command not zero");
endmodule

bind servo_monitor_display_select servo_monitor_checker i_chk (
	.CLK_I     (CLK_I),
	.RESET_N_I (RESET_N_I),
	.FLAGS_I   (FLAGS_I),
	.DISPLAY_O (DISPLAY_O)
);

// file: servo_keypad_model.sv
`timescale 1ns/1ps
// Operator keypad, one level per key, mode key on the top bit
module servo_keypad_model (
	input  wire logic       clk_i,
	output logic      [5:0] keys_o
);
	initial keys_o = 6'h00;
	// Both phases outlast the pin filter, else a press is lost
	task press(input int k);
		keys_o[k] <= 1'b1;
		repeat (6) @(posedge clk_i);
		keys_o[k] <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask
endmodule

// file: servo_monitor_display_select_tb_top.sv
`timescale 1ns/1ps
`include "servo_monitor_defs.svh"
module servo_monitor_display_select_tb_top;
	logic                            clk, rst_n, psel, pen, pwr, e;
	logic                            pready, pslverr;
	logic [11:0]                     paddr;
	logic [31:0]                     pwdata, prdata, d, seed, th;
	logic [5:0]                      keys;
	logic [14:0]                     pins, pv;
	logic [3:0]                      cur;
	logic [1:0]                      c;
	servo_monitor_pkg::pin_in_t      pin_w;
	servo_monitor_pkg::drive_flags_t flags, fv;
	servo_monitor_pkg::quantities_t  quant, qv;
	servo_monitor_pkg::display_t     disp;
	int                              mismatches, samples_checked, i, j;
	logic [3:0]                      its [8] = '{0, 1, 1, 2, 3, 4, 7, 8};
	logic [1:0]                      ms [6] = '{1, 3, 2, 0, 1, 3};

	assign pin_w = {keys, pins};
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	servo_monitor_display_select #(.PULSE_HOLD_CYC(8)) i_dut (
		.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.PIN_I(pin_w), .FLAGS_I(flags), .QUANT_I(quant), .DISPLAY_O(disp));
	servo_keypad_model i_pad (.clk_i(clk), .keys_o(keys));

	task print_verdict;
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, x, g);
		end
	endtask
	// One APB transfer; an edge first so a release never meets a new setup
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int k;
		@(posedge clk);
		psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			mismatches++;
			print_verdict;
		end
		d = prdata;
		e = pslverr;
		psel <= 1'b0; pen <= 1'b0;
	endtask
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task go(input logic [3:0] n);
		while (cur < n) begin
			i_pad.press(3);
			cur++;
		end
		while (cur > n) begin
			i_pad.press(2);
			cur--;
		end
	endtask
	// Expected item value, angle taken as it is, counts masked to one turn
	function automatic logic [31:0] exp_val(input logic [3:0] k,
		input servo_monitor_pkg::quantities_t q, input logic p);
		case (k)
			4'h0: return q.speed_fb;
			4'h1: return p ? 32'h0000_0000 : q.speed_cmd;
			4'h2: return q.torque_pct;
			4'h3: return q.u_phase_pulses & 32'h0000_1FFF;
			4'h4: return q.elec_angle_deg;
			4'h7: return q.cmd_pulse_rpm;
			default: return q.position_deviation;
		endcase
	endfunction
	// Expected status word one, bit n at index n-1
	function automatic logic [19:0] exp_w1(
		input servo_monitor_pkg::drive_flags_t f, input logic [14:0] p,
		input logic [1:0] cs, input logic signed [31:0] sp,
		input logic [31:0] t);
		logic [19:0] w;
		logic [31:0] a;
		a = sp < 0 ? -sp : sp;
		w = 20'h00000;
		w[0] = f.alarm_active_flag;
		w[1] = f.dyn_brake_active;
		w[2] = cs[0];
		w[3] = cs[1] ? f.torque_limited : (a >= t);
		w[4] = f.speed_reached_flag;
		w[5] = f.prop_only_control;
		w[7:6] = {p[7], p[8]};
		w[8] = f.motor_energized;
		for (int k = 0; k < 6; k++) w[9+k] = p[14-k];
		for (int k = 0; k < 4; k++) w[15+k] = p[6-k];
		return w;
	endfunction
	task pulse(input int b, input int n);
		repeat (n) begin
			pins[b] <= 1'b1;
			repeat (5) @(posedge clk);
			pins[b] <= 1'b0;
			repeat (5) @(posedge clk);
		end
	endtask

	// Watchdog against a hung handshake or key
	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		print_verdict;
	end

	initial begin
		rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h000;
		pwdata = 32'h0000_0000; pins = 15'h0000; flags = '0; quant = '0;
		seed = 32'h0000_CD7A; cur = 4'h0; mismatches = 0; samples_checked = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("reset mode", 32'h0, disp.mode);
		apb(1'b0, `OFS_CTRL, seed);
		chk("ctrl reset", `CTRL_RST, d);
		apb(1'b0, `OFS_THRESH, seed);
		chk("thresh reset", 32'h0000_0014, d);
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk("status reset", 32'h0, d);
		apb(1'b0, {1'b1, seed[10:0]}, seed);
		chk("unmapped err", 32'h1, e);
		chk("unmapped data", 32'h0, d);
		// Walk the whole mode cycle into monitor mode
		for (i = 0; i < 6; i++) begin
			i_pad.press(5);
			apb(1'b0, `OFS_STATUS, seed);
			chk("status mode", 32'(ms[i]) << 12, d);
		end
		i_pad.press(2);
		chk("item floor", 32'h0, disp.item);
		// Left shift selects the tens digit, right shift the units
		i_pad.press(1);
		chk("tens digit", 32'h1, disp.digit_tens);
		i_pad.press(3);
		chk("tens step", 32'h9, disp.item);
		i_pad.press(2);
		chk("tens floor", 32'h0, disp.item);
		i_pad.press(0);
		chk("units digit", 32'h0, disp.digit_tens);
		repeat (11) i_pad.press(3);
		chk("item ceiling", 32'h9, disp.item);
		cur = 4'h9;
		i_pad.press(4);
		chk("show value", 32'h1, disp.show_value);
		i_pad.press(3);
		chk("item frozen", 32'h9, disp.item);
		i_pad.press(4);
		chk("show number", 32'h0, disp.show_value);
		// Each numeric item but 09, speed command with and without pulse trains
		for (i = 0; i < 8; i++) begin
			go(its[i]);
			for (j = 0; j < 7; j++) begin
				seed = nx(seed);
				qv[j*32 +: 32] = seed;
			end
			quant <= qv;
			flags <= {6'h00, i == 1};
			i_pad.press(4);
			chk("item value", exp_val(its[i], qv, i == 1), disp.value);
			apb(1'b0, `OFS_VALUE, seed);
			chk("value reg", exp_val(its[i], qv, i == 1), d);
			i_pad.press(4);
		end
		go(5);
		i_pad.press(4);
		for (i = 0; i < 8; i++) begin
			seed = nx(seed);
			fv = seed[6:0];
			pv = {seed[22:11], 3'h0};
			c = seed[24:23];
			th = {26'h0, seed[30:25]};
			seed = nx(seed);
			qv.speed_fb = {{25{seed[6]}}, seed[6:0]};
			apb(1'b1, `OFS_CTRL, {30'h0, c});
			apb(1'b1, `OFS_THRESH, th);
			flags <= fv;
			pins <= pv;
			quant <= qv;
			repeat (8) @(posedge clk);
			chk("word one", exp_w1(fv, pv, c, qv.speed_fb, th), disp.segments);
			apb(1'b0, `OFS_WORD_ONE, seed);
			chk("word one reg", exp_w1(fv, pv, c, qv.speed_fb, th), d);
			chk("bit view", 32'h1, disp.show_bits);
		end
		i_pad.press(4);
		pins <= pv;
		go(6);
		i_pad.press(4);
		// Word-one pins stay random; word two must ignore them
		pins <= {pv[14:3], 3'h1};
		repeat (8) @(posedge clk);
		chk("word two clear", 32'h4, disp.segments);
		pins <= {pv[14:3], 3'h4};
		repeat (7) @(posedge clk);
		chk("word two pulse", 32'h1, disp.segments);
		pins <= pv;
		repeat (30) @(posedge clk);
		chk("word two idle", 32'h0, disp.segments);
		pulse(2, 2);
		pulse(1, 2);
		apb(1'b0, `OFS_PULSE_COUNT, seed);
		chk("pulse count", 32'h1, d);
		i_pad.press(4);
		go(9);
		i_pad.press(4);
		chk("count value", 32'h1, disp.value);
		apb(1'b1, `OFS_PULSE_COUNT, seed);
		apb(1'b0, `OFS_PULSE_COUNT, 32'h0);
		chk("count cleared", `COUNT_RST, d);
		print_verdict;
	end
endmodule
